// ### core/eigp_defines.svh
// Register indices, field positions, reset values and timing counts of the
// edge interrupt GPIO port. Included by the port module eigp_port.
`ifndef EIGP_DEFINES_SVH
`define EIGP_DEFINES_SVH

// Register indices on the plain register port
`define EIGP_REG_DIR 4'h0
`define EIGP_REG_LATCH 4'h1
`define EIGP_REG_LEVEL 4'h2
`define EIGP_REG_FALL 4'h3
`define EIGP_REG_RISE 4'h4
`define EIGP_REG_PEND 4'h5
`define EIGP_REG_SET 4'h6
`define EIGP_REG_CLR 4'h7
`define EIGP_REG_CONF 4'h8
`define EIGP_REG_ENG0 4'h9
`define EIGP_REG_ENG1 4'hA
`define EIGP_REG_IMASK 4'hB

// Bit mapper selector fields
`define EIGP_ZERO_PIN_LSB 0
`define EIGP_ZERO_WORD_LSB 4
`define EIGP_ONE_PIN_LSB 8
`define EIGP_ONE_WORD_LSB 12

// Reset values
`define EIGP_RST_ZERO 16'h0000
`define EIGP_RST_IMASK 16'hFFFF

// Input path: cycles from pin to level register
`define EIGP_SYNC_STAGES 2

`endif

// ### core/eigp_pkg.sv
// Types shared by the edge interrupt GPIO port modules.
// Assumes the defines header is on the include path.
package eigp_pkg;
  typedef logic [15:0] eigp_word_t;
  typedef logic [3:0] eigp_sel_t;
  typedef logic [3:0] eigp_addr_t;
endpackage : eigp_pkg

// ### core/eigp_evt_if.sv
// Carrier between register bank and edge capture of the GPIO port.
// Assumes both ends share mclk.
`timescale 1ns/1ps
`default_nettype none
interface eigp_evt_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] pend;
  logic [WIDTH-1:0] fall_en;
  logic [WIDTH-1:0] rise_en;
  logic clr_we;
  logic [WIDTH-1:0] clr_data;
  modport edge_side (output level, output pend, input fall_en, input rise_en,
    input clr_we, input clr_data);
  modport regs_side (input level, input pend, output fall_en, output rise_en,
    output clr_we, output clr_data);
endinterface : eigp_evt_if
`default_nettype wire

// ### core/eigp_edge.sv
// Pin synchroniser, edge detection and sticky pending flags.
// Assumes pins are sampled on mclk; flags cleared by write-one from regs.
`timescale 1ns/1ps
`default_nettype none
module eigp_edge
  import eigp_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  eigp_evt_if.edge_side evt
);
  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] pend_r;
  logic [WIDTH-1:0] rise_ev;
  logic [WIDTH-1:0] fall_ev;
  logic [WIDTH-1:0] clr_bits;

  // Two-stage synchroniser, then previous sample
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // RULE16 sample compare
  // RULE3 rising edge event
  assign rise_ev = sync2_r & ~prev_r & evt.rise_en;
  // RULE2 falling edge event
  assign fall_ev = ~sync2_r & prev_r & evt.fall_en;
  assign clr_bits = evt.clr_we ? evt.clr_data : '0;

  // RULE17 set beats clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~clr_bits) | rise_ev | fall_ev;
    end
  end

  assign evt.level = sync2_r;
  assign evt.pend = pend_r;

  property p_fall_sets;
    @(posedge mclk) disable iff (rst)
      (|fall_ev) |=> ((pend_r & $past(fall_ev)) == $past(fall_ev));
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost"); // RULE2

  property p_rise_sets;
    @(posedge mclk) disable iff (rst)
      (|rise_ev) |=> ((pend_r & $past(rise_ev)) == $past(rise_ev));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost"); // RULE3

  property p_no_spurious;
    @(posedge mclk) disable iff (rst)
      (sync2_r == prev_r) |=> ((pend_r & ~$past(pend_r)) == '0);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag without edge"); // RULE16

  property p_set_wins;
    @(posedge mclk) disable iff (rst)
      (evt.clr_we && |(evt.clr_data & (rise_ev | fall_ev)))
        |=> ((pend_r & $past(rise_ev | fall_ev)) == $past(rise_ev | fall_ev));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat an event"); // RULE17
endmodule : eigp_edge
`default_nettype wire

// ### core/eigp_port.sv
// Edge interrupt GPIO port: register bank, output latch, bit mappers,
// pin drivers and interrupt output.
// Assumes one clock mclk, synchronous inputs and a strobe register port.
//
// Notes on behaviour
// RULE1: Reading the level register returns every pin's present level in any direction.
// RULE2: A falling edge on a pin with its falling enable set raises its pending flag.
// RULE3: A rising edge on a pin with its rising enable set raises its pending flag.
// RULE4: The interrupt output is high while any pending flag is set; the code counts only flags whose imask_r bit is set.
// RULE5: Writing the pending register clears flags written as one, keeps the rest.
// RULE6: The interrupt stays high until every pending flag has been cleared; the code drops it once no flag with its imask_r bit set remains.
// RULE7: A set-mask write ORs the mask into the output latch.
// RULE8: A clear-mask write ANDs the inverted mask into the output latch.
// RULE9: The mapper config holds word and pin selectors for mappers one and zero.
// RULE10: A mapper write copies its selected word bit into its selected latch bit.
// RULE11: A mapper read returns its selected pin level at its word position, else zero.
// RULE12: Direction one makes a pin an output, zero an input, and all reset to input.
// RULE13: A direction change leaves the output latch alone.
// RULE14: The port has sixteen pins, each with all its own bits.
// RULE15: The source select drives a pin from a peripheral when one, else from the latch.
// RULE16: Edges come from comparing successive synchronised samples, once per transition.
// RULE17: An edge in the same cycle as a clear keeps the flag set.
`include "eigp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module eigp_port
  import eigp_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] pin_source_select,
  input wire logic [WIDTH-1:0] periph_out,
  output logic irq
);
  // RULE14 sixteen pins only
  if (WIDTH != 16) begin : g_width_check
    $error("eigp_port needs WIDTH of 16");
  end

  eigp_word_t dir_r;
  eigp_word_t output_latch;
  eigp_word_t fall_en_r;
  eigp_word_t rise_en_r;
  eigp_word_t conf_r;
  eigp_word_t imask_r;
  eigp_word_t rdata_r;
  eigp_word_t rdata_nxt;
  eigp_word_t latch_nxt;
  logic [WIDTH-1:0] pin_out_r;
  logic [WIDTH-1:0] pin_oe_r;
  logic irq_r;
  eigp_sel_t mapper_zero_pin_pos;
  eigp_sel_t mapper_zero_word_pos;
  eigp_sel_t mapper_one_pin_pos;
  eigp_sel_t mapper_one_word_pos;

  eigp_evt_if #(.WIDTH(WIDTH)) evt ();

  // Edge capture and pending flags
  eigp_edge #(.WIDTH(WIDTH)) u_edge (
    .mclk(mclk),
    .rst(rst),
    .pin_in(pin_in),
    .evt(evt.edge_side)
  );

  // Address match for a given register index
  function automatic logic hit(input eigp_addr_t a, input eigp_addr_t idx);
    hit = (a == idx);
  endfunction : hit

  // Mapper read word: one pin level placed at one word position
  function automatic eigp_word_t map_read(input eigp_word_t lvl,
                                          input eigp_sel_t pin_pos,
                                          input eigp_sel_t word_pos);
    map_read = '0;
    map_read[word_pos] = lvl[pin_pos];
  endfunction : map_read

  // RULE9 selector fields
  assign mapper_zero_pin_pos = conf_r[`EIGP_ZERO_PIN_LSB +: 4];
  assign mapper_zero_word_pos = conf_r[`EIGP_ZERO_WORD_LSB +: 4];
  assign mapper_one_pin_pos = conf_r[`EIGP_ONE_PIN_LSB +: 4];
  assign mapper_one_word_pos = conf_r[`EIGP_ONE_WORD_LSB +: 4];

  // Enables and clear strobe toward edge capture
  assign evt.fall_en = fall_en_r;
  assign evt.rise_en = rise_en_r;
  // RULE5 write-one clear
  assign evt.clr_we = wr && hit(addr, `EIGP_REG_PEND);
  assign evt.clr_data = wdata;

  // Direction register
  always_ff @(posedge mclk) begin
    if (rst) begin
      dir_r <= `EIGP_RST_ZERO;
    end else if (wr && hit(addr, `EIGP_REG_DIR)) begin
      dir_r <= wdata;
    end
  end

  // Edge enables, mapper config and interrupt mask
  always_ff @(posedge mclk) begin
    if (rst) begin
      fall_en_r <= `EIGP_RST_ZERO;
      rise_en_r <= `EIGP_RST_ZERO;
      conf_r <= `EIGP_RST_ZERO;
      imask_r <= `EIGP_RST_IMASK;
    end else if (wr) begin
      if (hit(addr, `EIGP_REG_FALL)) begin
        fall_en_r <= wdata;
      end
      if (hit(addr, `EIGP_REG_RISE)) begin
        rise_en_r <= wdata;
      end
      if (hit(addr, `EIGP_REG_CONF)) begin
        conf_r <= wdata;
      end
      if (hit(addr, `EIGP_REG_IMASK)) begin
        imask_r <= wdata;
      end
    end
  end

  // Next output latch value from the writing registers
  always_comb begin
    latch_nxt = output_latch;
    if (wr) begin
      unique case (addr)
        `EIGP_REG_LATCH: begin
          latch_nxt = wdata;
        end
        // RULE7 OR in mask
        `EIGP_REG_SET: begin
          latch_nxt = output_latch | wdata;
        end
        // RULE8 AND inverted mask
        `EIGP_REG_CLR: begin
          latch_nxt = output_latch & ~wdata;
        end
        // RULE10 mapper zero write
        `EIGP_REG_ENG0: begin
          latch_nxt[mapper_zero_pin_pos] = wdata[mapper_zero_word_pos];
        end
        // RULE10 mapper one write
        `EIGP_REG_ENG1: begin
          latch_nxt[mapper_one_pin_pos] = wdata[mapper_one_word_pos];
        end
        default: begin
          latch_nxt = output_latch;
        end
      endcase
    end
  end

  // RULE13 latch independent of direction
  always_ff @(posedge mclk) begin
    if (rst) begin
      output_latch <= `EIGP_RST_ZERO;
    end else begin
      output_latch <= latch_nxt;
    end
  end

  // Read multiplexer; unmapped and write-only read as zero
  always_comb begin
    rdata_nxt = '0;
    unique case (addr)
      `EIGP_REG_DIR: rdata_nxt = dir_r;
      `EIGP_REG_LATCH: rdata_nxt = output_latch;
      // RULE1 synchronised pin levels
      `EIGP_REG_LEVEL: rdata_nxt = evt.level;
      `EIGP_REG_FALL: rdata_nxt = fall_en_r;
      `EIGP_REG_RISE: rdata_nxt = rise_en_r;
      `EIGP_REG_PEND: rdata_nxt = evt.pend;
      `EIGP_REG_CONF: rdata_nxt = conf_r;
      // RULE11 mapper reads
      `EIGP_REG_ENG0: begin
        rdata_nxt = map_read(evt.level, mapper_zero_pin_pos, mapper_zero_word_pos);
      end
      `EIGP_REG_ENG1: begin
        rdata_nxt = map_read(evt.level, mapper_one_pin_pos, mapper_one_word_pos);
      end
      `EIGP_REG_IMASK: rdata_nxt = imask_r;
      default: rdata_nxt = '0;
    endcase
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  // Per-pin drivers
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    always_ff @(posedge mclk) begin
      if (rst) begin
        pin_out_r[i] <= 1'b0;
        pin_oe_r[i] <= 1'b0;
      end else begin
        // RULE15 peripheral or latch
        pin_out_r[i] <= pin_source_select[i] ? periph_out[i] : output_latch[i];
        // RULE12 one means output
        pin_oe_r[i] <= dir_r[i];
      end
    end
  end

  // RULE4 RULE6 level interrupt
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt.pend & imask_r);
    end
  end

  assign rdata = rdata_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign irq = irq_r;

  // Checks
  sequence s_rd_level;
    rd && hit(addr, `EIGP_REG_LEVEL);
  endsequence

  sequence s_wr_eng0;
    wr && hit(addr, `EIGP_REG_ENG0);
  endsequence

  property p_level_read;
    @(posedge mclk) disable iff (rst)
      s_rd_level |=> (rdata == $past(evt.level));
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read wrong"); // RULE1

  property p_irq_pend;
    @(posedge mclk) disable iff (rst)
      (|(evt.pend & imask_r)) |=> irq;
  endproperty
  a_irq_pend: assert property (p_irq_pend) else $error("irq missing"); // RULE4

  property p_irq_low;
    @(posedge mclk) disable iff (rst)
      ((evt.pend & imask_r) == '0) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq without pending flag"); // RULE4

  property p_irq_holds;
    @(posedge mclk) disable iff (rst)
      (irq && evt.clr_we && |(evt.pend & imask_r & ~evt.clr_data))
        |=> ##1 irq;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("irq dropped early"); // RULE6

  property p_clear_pend;
    @(posedge mclk) disable iff (rst)
      evt.clr_we |=> (((evt.pend & $past(evt.clr_data)) &
                       ~($past(evt.level) ^ $past(evt.level, 2))) == '0)
                     && ((evt.pend & $past(evt.pend) & ~$past(evt.clr_data)) ==
                      ($past(evt.pend) & ~$past(evt.clr_data)));
  endproperty
  a_clear_pend: assert property (p_clear_pend) else $error("clear hit kept flag"); // RULE5

  property p_set_mask;
    @(posedge mclk) disable iff (rst)
      (wr && hit(addr, `EIGP_REG_SET))
        |=> (output_latch == ($past(output_latch) | $past(wdata)));
  endproperty
  a_set_mask: assert property (p_set_mask) else $error("set mask wrong"); // RULE7

  property p_clr_mask;
    @(posedge mclk) disable iff (rst)
      (wr && hit(addr, `EIGP_REG_CLR))
        |=> (output_latch == ($past(output_latch) & ~$past(wdata)));
  endproperty
  a_clr_mask: assert property (p_clr_mask) else $error("clear mask wrong"); // RULE8

  property p_eng0_write;
    @(posedge mclk) disable iff (rst)
      s_wr_eng0 |=> (output_latch[$past(mapper_zero_pin_pos)] ==
                     $past(wdata[mapper_zero_word_pos]));
  endproperty
  a_eng0_write: assert property (p_eng0_write) else $error("mapper write wrong"); // RULE10

  property p_eng1_write;
    @(posedge mclk) disable iff (rst)
      (wr && hit(addr, `EIGP_REG_ENG1))
        |=> (output_latch[$past(mapper_one_pin_pos)] == $past(wdata[mapper_one_word_pos]))
            && ((output_latch & ~(16'h0001 << $past(mapper_one_pin_pos))) ==
                ($past(output_latch) & ~(16'h0001 << $past(mapper_one_pin_pos))));
  endproperty
  a_eng1_write: assert property (p_eng1_write) else $error("mapper one write wrong"); // RULE10

  property p_eng1_read;
    @(posedge mclk) disable iff (rst)
      (rd && hit(addr, `EIGP_REG_ENG1))
        |=> (rdata == map_read($past(evt.level), $past(mapper_one_pin_pos),
                               $past(mapper_one_word_pos)));
  endproperty
  a_eng1_read: assert property (p_eng1_read) else $error("mapper read wrong"); // RULE11

  property p_eng0_read;
    @(posedge mclk) disable iff (rst)
      (rd && hit(addr, `EIGP_REG_ENG0))
        |=> (rdata == map_read($past(evt.level), $past(mapper_zero_pin_pos),
                               $past(mapper_zero_word_pos)));
  endproperty
  a_eng0_read: assert property (p_eng0_read) else $error("mapper zero read wrong"); // RULE11

  property p_dir_reset;
    @(posedge mclk) $past(rst) |-> (pin_oe == '0);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("pin not input after reset"); // RULE12

  property p_dir_keeps_latch;
    @(posedge mclk) disable iff (rst)
      (wr && hit(addr, `EIGP_REG_DIR)) |=> (output_latch == $past(output_latch));
  endproperty
  a_dir_keeps_latch: assert property (p_dir_keeps_latch) else $error("latch moved"); // RULE13

  property p_source_sel;
    @(posedge mclk) disable iff (rst)
      ##1 (pin_out == (($past(pin_source_select) & $past(periph_out)) |
                       (~$past(pin_source_select) & $past(output_latch))));
  endproperty
  a_source_sel: assert property (p_source_sel) else $error("pin source wrong"); // RULE15
endmodule : eigp_port
`default_nettype wire

// ### verification/eigp_pin_model.sv
// Outside world of the GPIO port: resolves each pin from port drive
// and the level of whatever hangs on the pin. Assumes push-pull drive.
`timescale 1ns/1ps
`default_nettype none
module eigp_pin_model
  import eigp_pkg::*;
(
  input wire eigp_word_t pin_out,
  input wire eigp_word_t pin_oe,
  input wire eigp_word_t ext_level,
  output logic [15:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : eigp_pin_model
`default_nettype wire

// ### verification/edge_irq_gpio_port_bench.sv
// Self-checking bench of the edge interrupt GPIO port.
// Assumes the port core, package and pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module edge_irq_gpio_port_bench
  import eigp_pkg::*;
();
  logic mclk = 1'b0;
  logic rst = 1'b1;
  eigp_addr_t addr = 4'h0;
  eigp_word_t wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  eigp_word_t rdata;
  eigp_word_t pin_in;
  eigp_word_t pin_out;
  eigp_word_t pin_oe;
  eigp_word_t sel = 16'h0000;
  eigp_word_t periph = 16'h0000;
  eigp_word_t ext = 16'h0000;
  logic irq;
  logic [31:0] seed = 32'h0001_6AC9;
  int miscompares = 0;
  int check_count = 0;
  eigp_word_t lat;
  eigp_word_t v;
  eigp_word_t w;
  eigp_word_t p;
  eigp_word_t conf;

  // Device under test and its pins
  eigp_port #(.WIDTH(16)) uut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_source_select(sel), .periph_out(periph), .irq(irq)
  );
  eigp_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  // Pseudo-random source, fixed start
  function automatic eigp_word_t rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction : rnd

  // Expected latch after a mapper write
  function automatic eigp_word_t eng_wr(input eigp_word_t l, input eigp_sel_t pp,
      input eigp_sel_t b, input eigp_word_t d);
    eng_wr = l;
    eng_wr[pp] = d[b];
  endfunction : eng_wr

  // Expected word of a mapper read
  function automatic eigp_word_t eng_rd(input eigp_word_t lv, input eigp_sel_t pp,
      input eigp_sel_t b);
    eng_rd = 16'h0000;
    eng_rd[b] = lv[pp];
  endfunction : eng_rd

  task automatic check(input eigp_word_t got, input eigp_word_t exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : check

  // One-cycle write strobe
  task automatic wr_reg(input eigp_addr_t a, input eigp_word_t d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input eigp_addr_t a, input eigp_word_t exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd_chk(i[3:0], (i == 11) ? 16'hFFFF : 16'h0000);
    end
    check({15'h0000, irq}, 16'h0000);
    // Set and clear masks on the latch
    wr_reg(4'h1, 16'hA5C3);
    lat = 16'hA5C3;
    repeat (4) begin
      w = rnd();
      wr_reg(4'h6, w);
      lat = lat | w;
      rd_chk(4'h1, lat);
      w = rnd();
      wr_reg(4'h7, w);
      lat = lat & ~w;
      rd_chk(4'h1, lat);
    end
    wr_reg(4'hE, 16'hFFFF);
    rd_chk(4'hE, 16'h0000);
    rd_chk(4'h6, 16'h0000);
    wr_reg(4'h6, 16'h0300);
    lat = lat | 16'h0300;
    // Output drive and edges made by the port itself
    wr_reg(4'h0, 16'hFFFF);
    tick(2);
    check(pin_oe, 16'hFFFF);
    check(pin_out, lat);
    rd_chk(4'h2, lat);
    wr_reg(4'h4, 16'hFFFF);
    wr_reg(4'h3, 16'hFFFF);
    wr_reg(4'h5, 16'hFFFF);
    wr_reg(4'h7, 16'hFFFF);
    tick(5);
    rd_chk(4'h5, lat);
    wr_reg(4'h5, 16'h0100);
    rd_chk(4'h5, lat & ~16'h0100);
    check({15'h0000, irq}, 16'h0001);
    wr_reg(4'hB, 16'h0000);
    tick(2);
    check({15'h0000, irq}, 16'h0000);
    wr_reg(4'hB, 16'hFFFF);
    wr_reg(4'h5, 16'hFFFF);
    tick(2);
    check({15'h0000, irq}, 16'h0000);
    wr_reg(4'h6, 16'hFFFF);
    lat = 16'hFFFF;
    tick(5);
    rd_chk(4'h5, 16'hFFFF);
    // Input pins with random levels, rising then falling enables
    wr_reg(4'h0, 16'h0000);
    tick(5);
    wr_reg(4'h5, 16'hFFFF);
    p = 16'h0000;
    for (int m = 0; m < 2; m++) begin
      wr_reg(4'h3, m ? 16'hFFFF : 16'h0000);
      wr_reg(4'h4, m ? 16'h0000 : 16'hFFFF);
      repeat (6) begin
        v = rnd();
        @(posedge mclk);
        ext <= v;
        tick(5);
        rd_chk(4'h2, v);
        rd_chk(4'h5, m ? (p & ~v) : (v & ~p));
        check({15'h0000, irq}, {15'h0000, |(m ? (p & ~v) : (v & ~p))});
        wr_reg(4'h5, 16'hFFFF);
        p = v;
      end
    end
    // Falling edges landing in the cycle of a pending clear
    @(posedge mclk);
    ext <= ~p;
    @(posedge mclk);
    wr_reg(4'h5, 16'hFFFF);
    rd_chk(4'h5, p);
    // Bit mappers with random selectors
    repeat (8) begin
      conf = rnd();
      v = rnd();
      wr_reg(4'h8, conf);
      rd_chk(4'h8, conf);
      @(posedge mclk);
      ext <= v;
      w = rnd();
      wr_reg(4'h9, w);
      lat = eng_wr(lat, conf[3:0], conf[7:4], w);
      w = rnd();
      wr_reg(4'hA, w);
      lat = eng_wr(lat, conf[11:8], conf[15:12], w);
      rd_chk(4'h1, lat);
      rd_chk(4'h9, eng_rd(v, conf[3:0], conf[7:4]));
      rd_chk(4'hA, eng_rd(v, conf[11:8], conf[15:12]));
    end
    // Peripheral or latch drive per pin
    wr_reg(4'h0, 16'hFFFF);
    repeat (4) begin
      w = rnd();
      v = rnd();
      @(posedge mclk);
      sel <= w;
      periph <= v;
      tick(2);
      check(pin_out, (w & v) | (~w & lat));
    end
    complete_run();
  end
endmodule : edge_irq_gpio_port_bench
`default_nettype wire
